// ===== logic/cftm_top.sv
// Passive CAN frame decoder and trigger matcher with register slave
// Behaviour
// RL1 - Start-of-frame condition triggers on every frame start
// RL2 - Id plus data: id, data, length all match
// RL3 - Error condition triggers on detected error frames
// RL4 - Data id condition: matching id, remote bit clear
// RL5 - Any id condition: matching id, data or remote
// RL6 - Remote id condition: matching id, remote bit set
// RL7 - All errors: error frames plus unclassifiable bus states
// RL8 - Overload condition triggers on overload frames
// RL9 - Ack error: acknowledge slot sampled recessive
// RL10 - Input select among channels, external, logic inputs; code applies it to start-of-frame only, channel 1 otherwise
// RL11 - Without decoding only start-of-frame condition accepted
// RL12 - Identifier 11 bits standard, 29 bits extended
// RL13 - Mask bit zero drops bit from compare
// RL14 - Data length zero to eight whole bytes
// RL15 - Sample point chosen from 60 to 87.5 percent
// RL16 - One-clock trigger pulse; restart on reset, change
`timescale 1ns/1ps
`default_nettype none
module cftm_top
   import cftm_pkg::*;
#(
   parameter bit ANALOG_ONLY = 1'b0, // Conditions other than start-of-frame rejected
   parameter bit TWO_CH      = 1'b0  // Only channels one and two
) (
   input  wire logic        clk,             // 20 MHz clock
   input  wire logic        rst_n,           // Async reset, active low
   input  wire logic [3:0]  analog_in,       // Channel comparators 1..4
   input  wire logic        ext_in,          // External input
   input  wire logic [15:0] logic_inputs,    // Digital inputs 0..15
   input  wire logic        decode_licensed, // Frame decoding enabled
   input  wire logic [5:0]  avs_address,     // Byte address
   input  wire logic        avs_read,        // Read request
   input  wire logic        avs_write,       // Write request
   input  wire logic [31:0] avs_writedata,   // Write data
   input  wire logic [3:0]  avs_byteenable,  // Write byte lanes
   output logic [31:0]      avs_readdata,    // Read data
   output logic             avs_waitrequest, // Low for one answer cycle
   output logic             trig_out,        // Trigger pulse
   output logic             irq              // Level interrupt
);
   typedef struct packed {
      cftm_cond_type cond;
      logic          ext;
      logic [3:0]    dlen;
      logic [2:0]    samp;
      logic [4:0]    src;
      logic [15:0]   bit_len;
      logic [28:0]   id_val;
      logic [28:0]   id_msk;
      logic [63:0]   dval;
      logic [63:0]   dmsk;
      logic [ST_W-1:0] stat;
      logic [ST_W-1:0] imask;
      cftm_fsm_type  fsm;
      logic [6:0]    cnt;
      logic [2:0]    same;
      logic          last;
      logic [28:0]   id;
      logic          rtr;
      logic          ide;
      logic [3:0]    dlc;
      logic [63:0]   data;
      logic [6:0]    dbits;
      logic          rx;
      logic          trig;
      logic          irq;
      logic          wreq;
      logic [31:0]   rdata;
   } cftm_state_type;

   cftm_state_type  s_q;
   cftm_state_type  s_d;
   cftm_bit_if      bi ();
   logic [31:0]     bm;
   logic [31:0]     rv;
   logic [31:0]     wv;
   logic [31:0]     ctrl_rv;
   logic [3:0]      wcond;
   logic [3:0]      wdlen;
   logic [4:0]      src_sel;
   logic [4:0]      dig_idx;
   logic            wr;
   logic            restart;
   logic            stuffed;
   logic            sof_go;
   logic            b;
   logic [3:0]      nb;
   logic [ST_W-1:0] ev;
   logic [ST_W-1:0] stat_clr;
   logic            ev_frm;
   logic            id_hit;
   logic            data_hit;
   logic            id_ok;
   logic [28:0]     id_pat;
   logic [28:0]     id_msk_e;
   logic [63:0]     dmsk_e;

   cftm_bit_sampler u_smp (
      .clk   (clk),
      .rst_n (rst_n),
      .bi    (bi)
   );

   cftm_masked_match #(.W(29)) u_id_match (
      .val  (s_q.id),
      .pat  (id_pat),
      .mask (id_msk_e),
      .hit  (id_hit)
   );

   cftm_masked_match #(.W(64)) u_data_match (
      .val  (s_q.data),
      .pat  (s_q.dval),
      .mask (dmsk_e),
      .hit  (data_hit)
   );

   assign bi.rx = s_q.rx;
   assign bi.bit_len = s_q.bit_len;
   assign bi.samp_sel = s_q.samp;

   always_comb begin
      // ========================================================
      // Register read view and byte lane merge
      bm = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
      ctrl_rv = '0;
      ctrl_rv[CTRL_COND_LSB +: 4] = s_q.cond;
      ctrl_rv[CTRL_EXT_BIT] = s_q.ext;
      ctrl_rv[CTRL_DLEN_LSB +: 4] = s_q.dlen;
      ctrl_rv[CTRL_SAMP_LSB +: 3] = s_q.samp;
      ctrl_rv[CTRL_SRC_LSB +: 5] = s_q.src;
      case (avs_address)
         OFS_CTRL:   rv = ctrl_rv;
         OFS_BITLEN: rv = {16'h0000, s_q.bit_len};
         OFS_IDVAL:  rv = {3'h0, s_q.id_val};
         OFS_IDMSK:  rv = {3'h0, s_q.id_msk};
         OFS_DVLO:   rv = s_q.dval[31:0];
         OFS_DVHI:   rv = s_q.dval[63:32];
         OFS_DMLO:   rv = s_q.dmsk[31:0];
         OFS_DMHI:   rv = s_q.dmsk[63:32];
         OFS_STAT:   rv = {26'h0, s_q.stat};
         OFS_IMASK:  rv = {26'h0, s_q.imask};
         OFS_STATE:  rv = {20'h0, s_q.cnt, s_q.rx, s_q.fsm};
         default:    rv = '0;
      endcase
      wv = (rv & ~bm) | (avs_writedata & bm);
      wcond = wv[CTRL_COND_LSB +: 4];
      wdlen = wv[CTRL_DLEN_LSB +: 4];
      s_d = s_q;
      ev = '0;
      stat_clr = '0;
      restart = 1'b0;
      // ========================================================
      // Bus slave: one wait cycle, then a one-cycle answer
      s_d.wreq = 1'b1;
      if ((avs_read || avs_write) && s_q.wreq) begin
         s_d.wreq = 1'b0;
         s_d.rdata = avs_read ? rv : 32'h0000_0000;
      end
      wr = avs_write && !s_q.wreq;
      if (wr) begin
         case (avs_address)
            OFS_CTRL: begin
               if (wcond >= NUM_COND || (wcond != COND_SOF
                   && (!decode_licensed || ANALOG_ONLY))) begin
                  ev[ST_REJ] = 1'b1; // RL11
               end else begin
                  s_d.cond = cftm_cond_type'(wcond);
               end
               s_d.ext = wv[CTRL_EXT_BIT]; // RL12
               s_d.dlen = (wdlen > MAX_BYTES) ? MAX_BYTES : wdlen; // RL14
               s_d.samp = wv[CTRL_SAMP_LSB +: 3]; // RL15
               s_d.src = wv[CTRL_SRC_LSB +: 5]; // RL10
               restart = (s_d.cond != s_q.cond) || (s_d.src != s_q.src)
                  || (s_d.ext != s_q.ext); // RL16
            end
            OFS_BITLEN: s_d.bit_len = wv[15:0];
            OFS_IDVAL:  s_d.id_val = wv[28:0];
            OFS_IDMSK:  s_d.id_msk = wv[28:0];
            OFS_DVLO:   s_d.dval[31:0] = wv;
            OFS_DVHI:   s_d.dval[63:32] = wv;
            OFS_DMLO:   s_d.dmsk[31:0] = wv;
            OFS_DMHI:   s_d.dmsk[63:32] = wv;
            OFS_STAT:   stat_clr = avs_writedata[ST_W-1:0] & bm[ST_W-1:0];
            OFS_IMASK:  s_d.imask = wv[ST_W-1:0];
            default: ;
         endcase
      end
      // ========================================================
      // Input selection, applied only for start-of-frame
      src_sel = (s_q.cond == COND_SOF) ? s_q.src : 5'h00; // RL10
      dig_idx = src_sel - SRC_DIG0;
      if (src_sel < SRC_EXT) begin
         s_d.rx = (TWO_CH && src_sel[1]) ? 1'b1 : analog_in[src_sel[1:0]];
      end else if (src_sel == SRC_EXT) begin
         s_d.rx = ext_in;
      end else if (src_sel <= SRC_DIGN) begin
         s_d.rx = logic_inputs[dig_idx[3:0]];
      end else begin
         s_d.rx = 1'b1;
      end
      // ========================================================
      // Frame decoder with bit destuffing
      b = bi.bit_val;
      sof_go = 1'b0;
      ev_frm = 1'b0;
      nb = (s_q.dlc > MAX_BYTES) ? MAX_BYTES : s_q.dlc;
      stuffed = (s_q.fsm >= FS_BID) && (s_q.fsm <= FS_CDEL);
      if (restart) begin
         s_d.fsm = FS_WAIT; // RL16
         s_d.cnt = '0;
      end else if (bi.bit_stb) begin
         s_d.cnt = s_q.cnt + 7'h01;
         if (stuffed && s_q.same == STUFF_RUN) begin
            if (b == s_q.last) begin
               ev[ST_ERR] = !b; // RL3
               ev[ST_UNK] = b; // RL7
               s_d.fsm = FS_WAIT;
               s_d.cnt = '0;
            end else begin
               s_d.cnt = s_q.cnt;
               s_d.last = b;
               s_d.same = 3'h1;
            end
         end else begin
            if (stuffed) begin
               s_d.last = b;
               s_d.same = (b == s_q.last) ? s_q.same + 3'h1 : 3'h1;
            end
            case (s_q.fsm)
               FS_WAIT: begin
                  if (!b) begin
                     s_d.cnt = '0;
                  end else if (s_q.cnt == IDLE_LAST) begin
                     s_d.fsm = FS_IDLE;
                     s_d.cnt = '0;
                  end
               end
               FS_IDLE: sof_go = !b;
               FS_BID: begin
                  s_d.id = {s_q.id[27:0], b};
                  if (s_q.cnt == BASE_ID_LAST) begin
                     s_d.fsm = FS_SRR;
                  end
               end
               FS_SRR: begin
                  s_d.rtr = b;
                  s_d.fsm = FS_IDE;
               end
               FS_IDE: begin
                  s_d.ide = b;
                  s_d.fsm = b ? FS_EID : FS_RES;
                  s_d.cnt = '0;
               end
               FS_EID: begin
                  s_d.id = {s_q.id[27:0], b}; // RL12
                  if (s_q.cnt == EXT_ID_LAST) begin
                     s_d.fsm = FS_RTR2;
                  end
               end
               FS_RTR2: begin
                  s_d.rtr = b;
                  s_d.fsm = FS_RES;
                  s_d.cnt = '0;
               end
               FS_RES: begin
                  if (s_q.cnt == {6'h00, s_q.ide}) begin
                     s_d.fsm = FS_DLC;
                     s_d.cnt = '0;
                  end
               end
               FS_DLC: begin
                  s_d.dlc = {s_q.dlc[2:0], b};
                  if (s_q.cnt == DLC_LAST) begin
                     s_d.cnt = '0;
                     s_d.fsm = (s_q.rtr || s_d.dlc == 4'h0) ? FS_CRC
                                                          : FS_DATA;
                  end
               end
               FS_DATA: begin
                  if (s_q.dbits < {s_q.dlen, 3'h0}) begin
                     s_d.data = {s_q.data[62:0], b}; // RL14
                     s_d.dbits = s_q.dbits + 7'h01;
                  end
                  if (s_q.cnt == {nb, 3'h0} - 7'h01) begin
                     s_d.fsm = FS_CRC;
                     s_d.cnt = '0;
                  end
               end
               FS_CRC: begin
                  if (s_q.cnt == CRC_LAST) begin
                     s_d.fsm = FS_CDEL;
                  end
               end
               FS_CDEL: begin
                  ev_frm = b;
                  ev[ST_UNK] = !b; // RL7
                  s_d.fsm = b ? FS_ACK : FS_WAIT;
                  s_d.cnt = '0;
               end
               FS_ACK: begin
                  ev[ST_ACK] = b; // RL9
                  s_d.fsm = FS_ADEL;
               end
               FS_ADEL: begin
                  ev[ST_UNK] = !b; // RL7
                  s_d.fsm = b ? FS_EOF : FS_WAIT;
                  s_d.cnt = '0;
               end
               FS_EOF: begin
                  if (!b) begin
                     ev[ST_OVL] = (s_q.cnt == EOF_LAST); // RL8
                     ev[ST_ERR] = (s_q.cnt != EOF_LAST); // RL3
                     s_d.fsm = FS_WAIT;
                     s_d.cnt = '0;
                  end else if (s_q.cnt == EOF_LAST) begin
                     s_d.fsm = FS_INT;
                     s_d.cnt = '0;
                  end
               end
               FS_INT: begin
                  if (!b && s_q.cnt == INT_LAST) begin
                     sof_go = 1'b1;
                  end else if (!b) begin
                     ev[ST_OVL] = 1'b1; // RL8
                     s_d.fsm = FS_WAIT;
                     s_d.cnt = '0;
                  end else if (s_q.cnt == INT_LAST) begin
                     s_d.fsm = FS_IDLE;
                  end
               end
               default: begin
                  s_d.fsm = FS_WAIT;
                  s_d.cnt = '0;
               end
            endcase
            if (sof_go) begin
               s_d.fsm = FS_BID;
               s_d.cnt = '0;
               s_d.last = 1'b0;
               s_d.same = 3'h1;
               s_d.id = '0;
               s_d.data = '0;
               s_d.dbits = '0;
            end
         end
      end
      // ========================================================
      // Pattern compare and trigger selection
      id_pat = s_q.ext ? s_q.id_val : {18'h0, s_q.id_val[10:0]}; // RL12
      id_msk_e = s_q.ext ? s_q.id_msk : {18'h0, s_q.id_msk[10:0]};
      for (int i = 0; i < 8; i++) begin
         dmsk_e[i*8 +: 8] = (4'(i) < s_q.dlen) ? s_q.dmsk[i*8 +: 8]
                                               : 8'h00; // RL14
      end
      id_ok = id_hit && (s_q.ide == s_q.ext);
      case (s_q.cond)
         COND_SOF: s_d.trig = sof_go || ev[ST_OVL]; // RL1
         COND_DATA: s_d.trig = ev_frm && !s_q.rtr && id_ok && data_hit
                               && (s_q.dlc == s_q.dlen); // RL2
         COND_ERR: s_d.trig = ev[ST_ERR]; // RL3
         data_id_cond: s_d.trig = ev_frm && !s_q.rtr && id_ok; // RL4
         any_id_cond: s_d.trig = ev_frm && id_ok; // RL5
         remote_id_cond: s_d.trig = ev_frm && s_q.rtr && id_ok; // RL6
         all_errors_cond: s_d.trig = ev[ST_ERR] || ev[ST_UNK]; // RL7
         COND_OVL: s_d.trig = ev[ST_OVL]; // RL8
         ack_error_cond: s_d.trig = ev[ST_ACK]; // RL9
         default: s_d.trig = 1'b0;
      endcase
      // ========================================================
      // Sticky status, new events win over clears
      ev[ST_TRIG] = s_d.trig; // RL16
      s_d.stat = (s_q.stat & ~stat_clr) | ev;
      s_d.irq = |(s_d.stat & s_d.imask);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.cond <= COND_SOF;
         s_q.fsm <= FS_WAIT; // RL16
         s_q.dlen <= DLEN_RST;
         s_q.samp <= SAMP_RST;
         s_q.bit_len <= BITLEN_RST;
         s_q.rx <= 1'b1;
         s_q.wreq <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign avs_readdata = s_q.rdata;
   assign avs_waitrequest = s_q.wreq;
   assign trig_out = s_q.trig;
   assign irq = s_q.irq;
endmodule : cftm_top
`default_nettype wire

// ===== include/cftm_pkg.sv
// Constants, fields and types shared by the frame trigger matcher
package cftm_pkg;
   // ===========================================================
   // Register byte offsets
   localparam logic [5:0] OFS_CTRL   = 6'h00;
   localparam logic [5:0] OFS_BITLEN = 6'h04;
   localparam logic [5:0] OFS_IDVAL  = 6'h08;
   localparam logic [5:0] OFS_IDMSK  = 6'h0c;
   localparam logic [5:0] OFS_DVLO   = 6'h10;
   localparam logic [5:0] OFS_DVHI   = 6'h14;
   localparam logic [5:0] OFS_DMLO   = 6'h18;
   localparam logic [5:0] OFS_DMHI   = 6'h1c;
   localparam logic [5:0] OFS_STAT   = 6'h20;
   localparam logic [5:0] OFS_IMASK  = 6'h24;
   localparam logic [5:0] OFS_STATE  = 6'h28;
   // ===========================================================
   // Control register fields
   localparam int CTRL_COND_LSB = 0;
   localparam int CTRL_EXT_BIT  = 4;
   localparam int CTRL_DLEN_LSB = 8;
   localparam int CTRL_SAMP_LSB = 12;
   localparam int CTRL_SRC_LSB  = 16;
   // ===========================================================
   // Reset values
   localparam logic [15:0] BITLEN_RST = 16'h0028;
   localparam logic [3:0]  DLEN_RST   = 4'h1;
   localparam logic [2:0]  SAMP_RST   = 3'h4;
   // ===========================================================
   // Status bit positions
   localparam int ST_TRIG = 0;
   localparam int ST_ERR  = 1;
   localparam int ST_OVL  = 2;
   localparam int ST_ACK  = 3;
   localparam int ST_UNK  = 4;
   localparam int ST_REJ  = 5;
   localparam int ST_W    = 6;
   // ===========================================================
   // Frame field limits, last bit counted from zero; stuff run, byte and condition counts
   localparam logic [2:0] STUFF_RUN    = 3'h5;
   localparam logic [6:0] BASE_ID_LAST = 7'h0a;
   localparam logic [6:0] EXT_ID_LAST  = 7'h11;
   localparam logic [6:0] DLC_LAST     = 7'h03;
   localparam logic [6:0] CRC_LAST     = 7'h0e;
   localparam logic [6:0] EOF_LAST     = 7'h06;
   localparam logic [6:0] INT_LAST     = 7'h02;
   localparam logic [6:0] IDLE_LAST    = 7'h0a;
   localparam logic [3:0] MAX_BYTES    = 4'h8;
   localparam logic [3:0] NUM_COND     = 4'h9;
   // ===========================================================
   // Input selection codes
   localparam logic [4:0] SRC_EXT  = 5'h04;
   localparam logic [4:0] SRC_DIG0 = 5'h05;
   localparam logic [4:0] SRC_DIGN = 5'h14;
   // Sample point as fraction of bit time in 1/1024:
   // 60, 62.5, 68, 70, 75, 80, 87.5, 87.5 percent
   localparam logic [9:0] SP_FRAC [8] = '{10'h266, 10'h280, 10'h2b8,
      10'h2cd, 10'h300, 10'h333, 10'h380, 10'h380};
   // ===========================================================
   typedef enum logic [3:0] {
      COND_SOF = 4'h0, COND_DATA = 4'h1, COND_ERR = 4'h2,
      data_id_cond = 4'h3, any_id_cond = 4'h4, remote_id_cond = 4'h5,
      all_errors_cond = 4'h6, COND_OVL = 4'h7, ack_error_cond = 4'h8
   } cftm_cond_type;
   typedef enum logic [3:0] {
      FS_WAIT = 4'h0, FS_IDLE = 4'h1, FS_BID = 4'h2, FS_SRR = 4'h3,
      FS_IDE = 4'h4, FS_EID = 4'h5, FS_RTR2 = 4'h6, FS_RES = 4'h7,
      FS_DLC = 4'h8, FS_DATA = 4'h9, FS_CRC = 4'ha, FS_CDEL = 4'hb,
      FS_ACK = 4'hc, FS_ADEL = 4'hd, FS_EOF = 4'he, FS_INT = 4'hf
   } cftm_fsm_type;
endpackage : cftm_pkg

// ===== include/cftm_bit_if.sv
// Bit timing link between decoder and bit sampler
`timescale 1ns/1ps
`default_nettype none
interface cftm_bit_if;
   logic        rx;       // Selected bus level
   logic [15:0] bit_len;  // Clocks per bit
   logic [2:0]  samp_sel; // Sample point choice
   logic        bit_stb;  // One pulse per sampled bit
   logic        bit_val;  // Sampled level, 1 recessive
   modport timing (input rx, bit_len, samp_sel, output bit_stb, bit_val);
   modport decode (output rx, bit_len, samp_sel, input bit_stb, bit_val);
endinterface : cftm_bit_if
`default_nettype wire

// ===== logic/cftm_masked_match.sv
// Masked pattern compare, one mask bit per value bit
`timescale 1ns/1ps
`default_nettype none
module cftm_masked_match #(
   parameter int W = 8 // Pattern width
) (
   input  wire logic [W-1:0] val,  // Received bits
   input  wire logic [W-1:0] pat,  // Programmed pattern
   input  wire logic [W-1:0] mask, // One selects a bit
   output logic              hit   // All selected bits equal
);
   assign hit = ~|((val ^ pat) & mask); // RL13
endmodule : cftm_masked_match
`default_nettype wire

// ===== logic/cftm_bit_sampler.sv
// Bit timing: edge resync and sample point strobe
`timescale 1ns/1ps
`default_nettype none
module cftm_bit_sampler
   import cftm_pkg::*;
(
   input  wire logic clk,   // System clock
   input  wire logic rst_n, // Async reset, active low
   cftm_bit_if.timing bi    // Bit link
);
   typedef struct packed {
      logic [15:0] cnt;
      logic        prev;
      logic        stb;
      logic        val;
   } cftm_smp_type;

   cftm_smp_type s_q;
   cftm_smp_type s_d;
   logic [25:0]  prod;

   always_comb begin
      prod = 26'(bi.bit_len) * 26'(SP_FRAC[bi.samp_sel]); // RL15
      s_d = s_q;
      s_d.stb = 1'b0;
      s_d.prev = bi.rx;
      if (s_q.prev && !bi.rx) begin
         s_d.cnt = 16'h0001;
      end else if (s_q.cnt >= bi.bit_len - 16'h0001) begin
         s_d.cnt = 16'h0000;
      end else begin
         s_d.cnt = s_q.cnt + 16'h0001;
      end
      if (s_q.cnt == prod[25:10]) begin
         s_d.stb = 1'b1; // RL15
         s_d.val = bi.rx;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.prev <= 1'b1;
         s_q.val <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign bi.bit_stb = s_q.stb;
   assign bi.bit_val = s_q.val;
endmodule : cftm_bit_sampler
`default_nettype wire

// ===== sim/cftm_properties.sv
// Port properties of the frame trigger matcher
`timescale 1ns/1ps
`default_nettype none
module cftm_properties (
   input wire logic        clk,             // Clock
   input wire logic        rst_n,           // Reset, active low
   input wire logic [5:0]  avs_address,     // Byte address
   input wire logic        avs_read,        // Read request
   input wire logic        avs_write,       // Write request
   input wire logic [31:0] avs_readdata,    // Read data
   input wire logic        avs_waitrequest, // Answer strobe
   input wire logic        trig_out,        // Trigger pulse
   input wire logic        irq              // Interrupt
);
   // ==========================================================
   // Bus and trigger relations
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wait_pulse_a: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("request not answered");
   wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer longer than one cycle");
   wait_cause_a: assert property (!avs_waitrequest
      |-> $past(avs_read) || $past(avs_write))
      else $error("answer without request");
   trig_pulse_a: assert property (trig_out |=> !trig_out)
      else $error("trigger longer than one cycle");
   irq_clear_a: assert property ($fell(irq) |-> $past(avs_write)
      || $past(avs_write, 2) || $past(avs_write, 3))
      else $error("interrupt dropped without write");
   unmapped_zero_a: assert property (avs_read && !avs_waitrequest
      && avs_address > 6'h28 |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!(avs_read || avs_write)
      |=> $stable(avs_readdata)) else $error("read data moved");
   rst_quiet_a: assert property (!$past(rst_n)
      |-> avs_waitrequest && !trig_out && !irq) else $error("busy at reset");
   cover property (trig_out);
   cover property ($rose(irq));
   cover property (avs_read && !avs_waitrequest);
endmodule : cftm_properties
bind cftm_top cftm_properties i_cftm_properties (.clk(clk), .rst_n(rst_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .trig_out(trig_out), .irq(irq));
`default_nettype wire

// ===== sim/cftm_can_node.sv
// Bus node model sending frames onto the observed line
`timescale 1ns/1ps
`default_nettype none
module cftm_can_node #(
   parameter int BIT = 8 // Clocks per bit
) (
   input  wire logic clk, // Sampling clock
   output var  logic tx   // Line level, 1 recessive
);
   // ==========================================================
   // Bit, stuffing and frame tasks
   logic last;
   int   run;
   initial tx = 1'b1;
   task automatic drive_bit(input logic b);
      tx <= b;
      repeat (BIT) @(posedge clk);
   endtask : drive_bit
   task automatic level(input logic b, input int n);
      repeat (n) drive_bit(b);
   endtask : level
   task automatic stuffed(input logic b);
      if (run == 5) begin
         drive_bit(~last);
         last = ~last;
         run = 1;
      end
      drive_bit(b);
      run = (b == last) ? run + 1 : 1;
      last = b;
   endtask : stuffed
   task automatic frame(input logic [10:0] id, input logic rtr, ack, ovl);
      logic [41:0] h;
      h = {1'b0, id, rtr, 2'b00, 4'h1, 8'ha5, 15'h0};
      last = 1'b1;
      run = 0;
      for (int i = 41; i >= 0; i--)
         if (!rtr || i > 22 || i < 15) stuffed(h[i]);
      if (run == 5) drive_bit(~last);
      drive_bit(1'b1);
      drive_bit(~ack);
      level(1'b1, 8);
      level(1'b0, ovl ? 6 : 0);
      level(1'b1, 11);
   endtask : frame
endmodule : cftm_can_node
`default_nettype wire

// ===== sim/cftm_tb_top.sv
// Self-checking bench for the frame trigger matcher
`timescale 1ns/1ps
`default_nettype none
module cftm_tb_top;
   import cftm_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, dl = 1'b1, rt = 1'b0;
   logic        rd = 1'b0, wr = 1'b0, tx, wreq, trg, irq;
   logic [5:0]  adr = 6'h00;
   logic [31:0] wd = 32'h0, rdat;
   int          fails = 0, samples_checked = 0, trigs = 0;
   // Condition, ext and source, route, id, ack, kind, expected triggers
   logic [39:0] tbl [15] = '{40'h0_00_0_123_1_0_2, 40'h1_00_0_123_1_0_1,
      40'h3_00_0_123_1_0_1, 40'h4_00_0_122_1_0_2, 40'h4_00_0_124_1_0_0,
      40'h5_00_0_123_1_0_1, 40'h8_00_0_123_0_0_2, 40'h2_00_0_123_1_1_1,
      40'h6_00_0_123_1_1_1, 40'h7_00_0_123_1_2_1, 40'h0_08_1_123_1_0_2,
      40'h0_00_1_123_1_0_0, 40'h3_08_1_123_1_0_0, 40'h4_20_0_123_1_0_0,
      40'h0_04_1_123_1_0_2};
   // ==========================================================
   // Clock, instances, tasks
   always #25 clk = ~clk;
   always @(posedge clk) if (trg === 1'b1) trigs <= trigs + 1;
   cftm_can_node #(.BIT(8)) i_cftm_can_node (.clk(clk), .tx(tx));
   cftm_top i_cftm_top (.clk(clk), .rst_n(rst_n),
      .analog_in({3'b111, rt | tx}), .ext_in(tx | ~rt),
      .logic_inputs({12'hfff, tx | ~rt, 3'b111}), .decode_licensed(dl),
      .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wreq),
      .trig_out(trg), .irq(irq));
   task automatic results;
      $display("checks %0d errors %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results
   task automatic cmp(input logic [31:0] g, e);
      samples_checked++;
      if (g !== e) begin
         $display("Error %0t got %h exp %h", $time, g, e);
         fails++;
      end
   endtask : cmp
   task automatic bus(input logic w, input logic [5:0] a,
      input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 40);
      r = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 40) begin
         fails++;
         results();
      end
      @(posedge clk);
   endtask : bus
   task automatic put(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : put
   task automatic chk(input logic [5:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      cmp(r, e);
   endtask : chk
   // ==========================================================
   // Main sequence
   initial begin
      logic [39:0] t;
      int          t0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk(OFS_CTRL, 32'h4100);
      chk(OFS_BITLEN, 32'h28);
      chk(6'h3c, 32'h0);
      dl <= 1'b0;
      put(OFS_CTRL, 32'h4103);
      chk(OFS_CTRL, 32'h4100);
      chk(OFS_STAT, 32'h20);
      dl <= 1'b1;
      put(OFS_STAT, 32'h3f);
      put(OFS_BITLEN, 32'h8);
      put(OFS_IDVAL, 32'h123);
      put(OFS_IDMSK, 32'h7fe);
      put(OFS_DVLO, 32'ha5);
      put(OFS_DMLO, 32'hff);
      put(OFS_IMASK, 32'h1);
      foreach (tbl[i]) begin
         t = tbl[i];
         rt <= t[24];
         put(OFS_CTRL, {11'h0, t[32:28], 1'b0, 3'(i), 7'h08, t[33],
            t[39:36]});
         i_cftm_can_node.level(1'b1, 12);
         t0 = trigs;
         if (t[7:4] == 4'h0) begin
            i_cftm_can_node.frame(t[22:12], 1'b0, t[8], 1'b0);
            i_cftm_can_node.frame(t[22:12], 1'b1, t[8], 1'b0);
         end else if (t[7:4] == 4'h1) begin
            i_cftm_can_node.level(1'b0, 12);
            i_cftm_can_node.level(1'b1, 14);
         end else
            i_cftm_can_node.frame(t[22:12], 1'b0, 1'b1, 1'b1);
         cmp(32'(trigs - t0), {28'h0, t[3:0]});
      end
      cmp({31'h0, irq}, 32'h1);
      put(OFS_IMASK, 32'h0);
      repeat (2) @(posedge clk);
      cmp({31'h0, irq}, 32'h0);
      put(OFS_IMASK, 32'h1);
      put(OFS_STAT, 32'h7f);
      repeat (2) @(posedge clk);
      cmp({31'h0, irq}, 32'h0);
      results();
   end
endmodule : cftm_tb_top
`default_nettype wire
